// *** hw/fcs_regs.vh ***
// constants of the flash command controller: command bytes, status bits, register map, timing
// assumes a 100 MHz clock; included by the controller and its pin sequencer
// How it works
// - after power-down release wait wake delays before writing or reading.
// - block erase is 20H then D0H, both at an address in the block.
// - a write is strobe low with chip select low, latched at strobe rise.
// - after supply low, clear status before any further erase or write.
// - mask status bits 2 to 0 when polling.
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

`define FCS_CMD_READ_ARRAY   8'hFF
`define FCS_CMD_READ_ID      8'h90
`define FCS_CMD_READ_STATUS  8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_ERASE_SETUP  8'h20
`define FCS_CMD_CONFIRM      8'hD0
`define FCS_CMD_SUSPEND      8'hB0
`define FCS_CMD_WRITE_SETUP  8'h40
`define FCS_CMD_WRITE_ALT    8'h10

`define FCS_SR_READY         7
`define FCS_SR_SUSPENDED     6
`define FCS_SR_ERASE_ERR     5
`define FCS_SR_WRITE_ERR     4
`define FCS_SR_SUPPLY_LOW    3
`define FCS_SR_MASK          8'hF8

`define FCS_ID_MAKER_ADDR    20'h0_0000
`define FCS_ID_PART_ADDR     20'h0_0001

// software register offsets
`define FCS_REG_CTRL         4'h0
`define FCS_REG_ADDR         4'h1
`define FCS_REG_DATA         4'h2
`define FCS_REG_STATUS       4'h3
`define FCS_REG_RESULT       4'h4
`define FCS_REG_FLASH_SR     4'h5

// ctrl write opcodes (wdata[3:0]) ; wdata[8] drives power-down release
`define FCS_OP_NONE          4'h0
`define FCS_OP_READ_ARRAY    4'h1
`define FCS_OP_READ          4'h2
`define FCS_OP_READ_ID       4'h3
`define FCS_OP_READ_STATUS   4'h4
`define FCS_OP_CLEAR_STATUS  4'h5
`define FCS_OP_ERASE         4'h6
`define FCS_OP_WRITE         4'h7
`define FCS_OP_SUSPEND       4'h8
`define FCS_OP_RESUME        4'h9
`define FCS_CTRL_WAKE_BIT    8

// pin timing, in ns, and derived counts at 10 ns
`define FCS_CLK_NS           10
`define FCS_STROBE_NS        50
`define FCS_STROBE_CYC       ((`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACCESS_NS        90
`define FCS_ACCESS_CYC       ((`FCS_ACCESS_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WAKE_WR_NS       1000
`define FCS_WAKE_WR_CYC      ((`FCS_WAKE_WR_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WAKE_RD_NS       400
`define FCS_WAKE_RD_CYC      ((`FCS_WAKE_RD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

// *** hw/fcs_pin_cycle.v ***
// one flash bus cycle: a write pulses the write strobe, a read samples the data pins
// assumes flash pins are registered here and the caller holds start for one cycle
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_pin_cycle #(
	parameter STROBE_CYC = `FCS_STROBE_CYC,
	parameter ACCESS_CYC = `FCS_ACCESS_CYC
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        start,
	input  wire        is_write,
	input  wire [19:0] addr,
	input  wire [7:0]  wdata,
	output wire        done,
	output reg  [7:0]  rdata_q,
	output reg  [19:0] flash_addr_q,
	output reg  [7:0]  flash_dq_out_q,
	output reg         flash_dq_oe_q,
	input  wire [7:0]  flash_dq_in,
	output reg         chip_select_n_q,
	output reg         output_enable_n_q,
	output reg         write_strobe_n_q
);
	localparam S_IDLE = 2'd0;
	localparam S_ACT  = 2'd1;
	localparam S_END  = 2'd2;
	reg [1:0] st_q;
	reg [7:0] cnt_q;
	reg       wr_q;

	assign done = (st_q == S_END);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q              <= S_IDLE;
			cnt_q             <= 8'h00;
			wr_q              <= 1'b0;
			rdata_q           <= 8'h00;
			flash_addr_q      <= 20'h0_0000;
			flash_dq_out_q    <= 8'h00;
			flash_dq_oe_q     <= 1'b0;
			chip_select_n_q   <= 1'b1;
			output_enable_n_q <= 1'b1;
			write_strobe_n_q  <= 1'b1;
		end else begin
			case (st_q)
			S_IDLE: begin
				if (start) begin
					st_q            <= S_ACT;
					wr_q            <= is_write;
					flash_addr_q    <= addr;
					flash_dq_out_q  <= wdata;
					// host drives the pins only while flash output is off
					flash_dq_oe_q   <= is_write;
					chip_select_n_q <= 1'b0;
					// write: strobe low while selected
					write_strobe_n_q  <= ~is_write;
					output_enable_n_q <= is_write;
					cnt_q <= is_write ? STROBE_CYC[7:0] : ACCESS_CYC[7:0];
				end
			end
			S_ACT: begin
				if (cnt_q <= 8'h01) begin
					st_q <= S_END;
					// strobe rises with address and data still held
					write_strobe_n_q  <= 1'b1;
					output_enable_n_q <= 1'b1;
					if (!wr_q)
						rdata_q <= flash_dq_in;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			S_END: begin
				st_q            <= S_IDLE;
				chip_select_n_q <= 1'b1;
				flash_dq_oe_q   <= 1'b0;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // fcs_pin_cycle

// *** hw/fcs_controller.v ***
// host controller for a byte-wide flash: software orders, command sequences, status polling
// assumes a flash with its command interface on the pins below, one 100 MHz clock
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_controller #(
	parameter WAKE_WR_CYC = `FCS_WAKE_WR_CYC,
	parameter WAKE_RD_CYC = `FCS_WAKE_RD_CYC
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata_q,
	output wire [19:0] flash_addr,
	output wire [7:0]  flash_dq_out,
	output wire        flash_dq_oe,
	input  wire [7:0]  flash_dq_in,
	output wire        chip_select_n,
	output wire        output_enable_n,
	output wire        write_strobe_n,
	output reg         power_down_n_q,
	input  wire        ready_busy_n
);
	localparam S_IDLE   = 3'd0;
	localparam S_CMD    = 3'd1;
	localparam S_SECOND = 3'd2;
	localparam S_POLL   = 3'd3;
	localparam S_READ   = 3'd4;
	localparam S_WAIT   = 3'd5;

	reg [2:0]  st_q;
	reg [3:0]  op_q;
	reg [19:0] addr_q;
	reg [7:0]  data_q;
	reg [7:0]  result_q;
	reg [7:0]  flash_sr_q;
	reg        err_q;
	reg        sr_mode_q;
	reg        need_clear_q;
	reg [15:0] wake_q;
	reg        start_q;
	reg        is_wr_q;
	reg [19:0] cyc_addr_q;
	reg [7:0]  cyc_data_q;
	wire       cyc_done;
	wire [7:0] cyc_rdata;

	function [7:0] op_cmd;
		input [3:0] op;
		begin
			case (op)
			`FCS_OP_READ_ARRAY:   op_cmd = `FCS_CMD_READ_ARRAY;
			`FCS_OP_READ_ID:      op_cmd = `FCS_CMD_READ_ID;
			`FCS_OP_READ_STATUS:  op_cmd = `FCS_CMD_READ_STATUS;
			`FCS_OP_CLEAR_STATUS: op_cmd = `FCS_CMD_CLEAR_STATUS;
			`FCS_OP_ERASE:        op_cmd = `FCS_CMD_ERASE_SETUP;
			`FCS_OP_WRITE:        op_cmd = `FCS_CMD_WRITE_SETUP;
			`FCS_OP_SUSPEND:      op_cmd = `FCS_CMD_SUSPEND;
			`FCS_OP_RESUME:       op_cmd = `FCS_CMD_CONFIRM;
			default:              op_cmd = `FCS_CMD_READ_STATUS;
			endcase
		end
	endfunction

	fcs_pin_cycle u_cycle (
		.clk               (clk),
		.rstn              (rstn),
		.start             (start_q),
		.is_write          (is_wr_q),
		.addr              (cyc_addr_q),
		.wdata             (cyc_data_q),
		.done              (cyc_done),
		.rdata_q           (cyc_rdata),
		.flash_addr_q      (flash_addr),
		.flash_dq_out_q    (flash_dq_out),
		.flash_dq_oe_q     (flash_dq_oe),
		.flash_dq_in       (flash_dq_in),
		.chip_select_n_q   (chip_select_n),
		.output_enable_n_q (output_enable_n),
		.write_strobe_n_q  (write_strobe_n)
	);

	wire busy      = (st_q != S_IDLE);
	wire wake_ok   = (wake_q == 16'h0000);
	wire op_write  = reg_wr && (reg_addr == `FCS_REG_CTRL);
	wire [3:0] op  = reg_wdata[3:0];
	// erase/write refused until status cleared after a supply-low report
	wire op_block  = need_clear_q && (op == `FCS_OP_ERASE || op == `FCS_OP_WRITE);
	wire op_take   = op_write && !busy && wake_ok && power_down_n_q
	                 && reg_wdata[`FCS_CTRL_WAKE_BIT] && (op != `FCS_OP_NONE) && !op_block;
	// suspend is the one order taken while an erase runs
	wire susp_take = op_write && reg_wdata[`FCS_CTRL_WAKE_BIT] && (op == `FCS_OP_SUSPEND)
	                 && (st_q == S_WAIT) && (op_q == `FCS_OP_ERASE || op_q == `FCS_OP_RESUME);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q           <= S_IDLE;
			op_q           <= `FCS_OP_NONE;
			addr_q         <= 20'h0_0000;
			data_q         <= 8'h00;
			result_q       <= 8'h00;
			flash_sr_q     <= 8'h80;
			err_q          <= 1'b0;
			sr_mode_q      <= 1'b0;
			need_clear_q   <= 1'b0;
			wake_q         <= 16'h0000;
			start_q        <= 1'b0;
			is_wr_q        <= 1'b0;
			cyc_addr_q     <= 20'h0_0000;
			cyc_data_q     <= 8'h00;
			power_down_n_q <= 1'b0;
			reg_rdata_q    <= 32'h0000_0000;
		end else begin
			start_q <= 1'b0;
			if (reg_wr && reg_addr == `FCS_REG_ADDR)
				addr_q <= reg_wdata[19:0];
			if (reg_wr && reg_addr == `FCS_REG_DATA)
				data_q <= reg_wdata[7:0];
			if (op_write && op_block)
				err_q <= 1'b1;
			if (!wake_ok)
				wake_q <= wake_q - 16'h0001;
			case (st_q)
			S_IDLE: begin
				if (op_take) begin
					op_q <= op;
					if (op == `FCS_OP_READ) begin
						// array read only in read-array mode
						cyc_addr_q <= addr_q;
						is_wr_q    <= 1'b0;
						start_q    <= 1'b1;
						st_q       <= S_READ;
					end else begin
						cyc_addr_q <= addr_q;
						cyc_data_q <= op_cmd(op);
						is_wr_q    <= 1'b1;
						start_q    <= 1'b1;
						st_q       <= S_CMD;
					end
				end
			end
			S_CMD: begin
				if (cyc_done) begin
					case (op_q)
					`FCS_OP_ERASE, `FCS_OP_WRITE: begin
						st_q <= S_SECOND;
						start_q <= 1'b1;
						// erase confirm in same block, write gives data
						cyc_data_q <= (op_q == `FCS_OP_ERASE) ? `FCS_CMD_CONFIRM : data_q;
					end
					`FCS_OP_READ_ID, `FCS_OP_READ_STATUS, `FCS_OP_SUSPEND: begin
						// identifier reads at its address; status reads anywhere
						sr_mode_q  <= (op_q != `FCS_OP_READ_ID);
						is_wr_q    <= 1'b0;
						start_q    <= 1'b1;
						st_q       <= (op_q == `FCS_OP_SUSPEND) ? S_WAIT : S_READ;
					end
					`FCS_OP_RESUME: begin
						// resumed erase is polled to its end
						sr_mode_q <= 1'b1;
						is_wr_q   <= 1'b0;
						st_q      <= S_WAIT;
					end
					`FCS_OP_CLEAR_STATUS: begin
						// supply-low and error bits only clear by command
						need_clear_q <= 1'b0;
						// a refused erase in the same cycle still counts
						err_q        <= op_write && op_block;
						flash_sr_q   <= flash_sr_q & 8'hC0;
						st_q         <= S_IDLE;
					end
					default: begin
						sr_mode_q <= 1'b0;
						st_q      <= S_IDLE;
					end
					endcase
				end
			end
			S_SECOND: begin
				if (cyc_done) begin
					// flash now answers status on every read
					sr_mode_q <= 1'b1;
					is_wr_q   <= 1'b0;
					st_q      <= S_WAIT;
				end
			end
			S_WAIT: begin
				if (susp_take) begin
					// suspend cuts into the running erase
					op_q       <= `FCS_OP_SUSPEND;
					cyc_data_q <= `FCS_CMD_SUSPEND;
					is_wr_q    <= 1'b1;
					start_q    <= 1'b1;
					st_q       <= S_CMD;
				// poll only once ready_busy_n is released
				end else if (ready_busy_n && !start_q) begin
					start_q <= 1'b1;
					st_q    <= S_POLL;
				end
			end
			S_POLL: begin
				if (cyc_done) begin
					// only the top five bits mean anything
					flash_sr_q <= cyc_rdata & `FCS_SR_MASK;
					if (!cyc_rdata[`FCS_SR_READY]) begin
						start_q <= 1'b1;
					end else begin
						st_q <= S_IDLE;
						// supply low from sampled status only
						if (cyc_rdata[`FCS_SR_SUPPLY_LOW])
							need_clear_q <= 1'b1;
						// erase or write failure, bad sequence when both, or supply low
						if (cyc_rdata[`FCS_SR_ERASE_ERR] || cyc_rdata[`FCS_SR_WRITE_ERR]
						    || cyc_rdata[`FCS_SR_SUPPLY_LOW])
							err_q <= 1'b1;
					end
				end
			end
			S_READ: begin
				if (cyc_done) begin
					result_q <= sr_mode_q ? (cyc_rdata & `FCS_SR_MASK) : cyc_rdata;
					if (sr_mode_q)
						flash_sr_q <= cyc_rdata & `FCS_SR_MASK;
					st_q <= S_IDLE;
				end
			end
			default: st_q <= S_IDLE;
			endcase
			// power-down wins over any step above
			if (reg_wr && reg_addr == `FCS_REG_CTRL) begin
				if (!reg_wdata[`FCS_CTRL_WAKE_BIT]) begin
					power_down_n_q <= 1'b0;
					st_q           <= S_IDLE;
					start_q        <= 1'b0;
					sr_mode_q      <= 1'b0;
				end else if (!power_down_n_q) begin
					power_down_n_q <= 1'b1;
					// wake delay before any command write
					wake_q    <= WAKE_WR_CYC[15:0];
					// flash returns in read-array with ready status
					flash_sr_q <= 8'h80;
				end
			end
			if (reg_rd) begin
				case (reg_addr)
				`FCS_REG_ADDR:     reg_rdata_q <= {12'h000, addr_q};
				`FCS_REG_DATA:     reg_rdata_q <= {24'h00_0000, data_q};
				`FCS_REG_STATUS:   reg_rdata_q <= {24'h00_0000, ready_busy_n, wake_ok,
				                                   power_down_n_q, need_clear_q, sr_mode_q,
				                                   err_q, 1'b0, busy};
				`FCS_REG_RESULT:   reg_rdata_q <= {24'h00_0000, result_q};
				`FCS_REG_FLASH_SR: reg_rdata_q <= {24'h00_0000, flash_sr_q};
				default:           reg_rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // fcs_controller

// *** verification/fcs_chk.sv ***
// pin and register-port checks for the flash command controller
// assumes bind to fcs_controller, one clock, fcs_regs.vh on the include path
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_chk #(
	parameter WAKE_WR_CYC = 100
) (
	input wire        clk,
	input wire        rstn,
	input wire [3:0]  reg_addr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata_q,
	input wire [19:0] flash_addr,
	input wire [7:0]  flash_dq_out,
	input wire        flash_dq_oe,
	input wire        chip_select_n,
	input wire        output_enable_n,
	input wire        write_strobe_n,
	input wire        power_down_n_q
);
	reg [15:0] wake_q;
	// cycles since power-down release, saturating
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			wake_q <= 16'h0000;
		else if (!power_down_n_q)
			wake_q <= 16'h0000;
		else if (wake_q < WAKE_WR_CYC)
			wake_q <= wake_q + 16'h0001;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_strobe;
		!write_strobe_n [*5] ##1 write_strobe_n;
	endsequence
	property p_strobe_len;
		$fell(write_strobe_n) |-> s_strobe;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("write strobe width");
	property p_we_cs;
		!write_strobe_n |-> !chip_select_n && output_enable_n && flash_dq_oe;
	endproperty
	a_we_cs: assert property (p_we_cs) else $error("write strobe outside select");
	property p_hold;
		$rose(write_strobe_n) |-> !chip_select_n && flash_dq_oe && $stable(flash_dq_out)
			&& $stable(flash_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("write data not held at strobe rise");
	property p_no_fight;
		!output_enable_n |-> !flash_dq_oe && write_strobe_n;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("data pins driven during read");
	property p_cs_rd;
		!output_enable_n |-> !chip_select_n;
	endproperty
	a_cs_rd: assert property (p_cs_rd) else $error("read without select");
	property p_wake_wr;
		!write_strobe_n |-> wake_q >= WAKE_WR_CYC;
	endproperty
	a_wake_wr: assert property (p_wake_wr) else $error("write too soon after wake");
	property p_wake_rd;
		!output_enable_n |-> wake_q >= WAKE_WR_CYC;
	endproperty
	a_wake_rd: assert property (p_wake_rd) else $error("read too soon after wake");
	property p_mask;
		reg_rd && reg_addr == `FCS_REG_FLASH_SR |=> reg_rdata_q[2:0] == 3'b000;
	endproperty
	a_mask: assert property (p_mask) else $error("reserved status bits not masked");
endmodule // fcs_chk

bind fcs_controller fcs_chk #(.WAKE_WR_CYC(WAKE_WR_CYC)) u_chk (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
	.write_strobe_n(write_strobe_n), .power_down_n_q(power_down_n_q));

// *** verification/fcs_flash_model.sv ***
// behavioural flash: command decoding, status byte, busy timing, 16-byte array
// assumes the controller's registered pins; the bench clock times the busy period
`timescale 1ns/1ps
module fcs_flash_model #(
	parameter MAKER    = 8'h5A, // arbitrary value
	parameter PART     = 8'hC3, // arbitrary value
	parameter BUSY_CYC = 40
) (
	input  wire        clk,
	input  wire [19:0] a,
	input  wire [7:0]  dout,
	input  wire        doe,
	output wire [7:0]  din,
	input  wire        cs_n,
	input  wire        oe_n,
	input  wire        we_n,
	input  wire        pd_n,
	output wire        rb_n,
	input  wire        vpp_ok
);
	reg     [7:0] mem_q [0:15];
	reg     [7:0] last_q;
	reg     [2:0] sr_q;
	reg     [1:0] mode_q;
	reg     [1:0] setup_q;
	reg     [7:0] busy_q;
	reg           susp_q;
	reg           we_q;
	integer       i;
	wire    [7:0] val;
	wire          drv;
	initial for (i = 0; i < 16; i = i + 1) mem_q[i] = i;
	assign drv = !cs_n && !oe_n && pd_n;
	// reserved status bits read 101 so an unmasked host shows it
	assign val = (mode_q == 2'd1) ? (a[0] ? PART : MAKER) :
		(mode_q == 2'd2) ? {rb_n, susp_q, sr_q, 3'b101} : mem_q[a[3:0]];
	// released pins show the inverse of the last value
	assign din = drv ? val : (doe ? dout : ~last_q);
	assign rb_n = (busy_q == 8'h00) || susp_q;
	always @(posedge clk)
		last_q <= din;
	always @(posedge clk or negedge pd_n) begin
		if (!pd_n) begin
			busy_q <= 8'h00;
			mode_q <= 2'd0;
			sr_q <= 3'b000;
			setup_q <= 2'd0;
			susp_q <= 1'b0;
			we_q <= 1'b1;
		end else begin
			we_q <= we_n;
			if (busy_q != 8'h00 && !susp_q)
				busy_q <= busy_q - 8'h01;
			if (!we_q && we_n && !cs_n) begin
				setup_q <= 2'd0;
				if (setup_q != 2'd0)
					mode_q <= 2'd2;
				if (setup_q == 2'd1 && dout == 8'hD0 && vpp_ok) begin
					busy_q <= BUSY_CYC[7:0];
					for (i = 0; i < 16; i = i + 1)
						mem_q[i] <= 8'hFF;
				end else if (setup_q == 2'd2 && vpp_ok) begin
					busy_q <= BUSY_CYC[7:0];
					mem_q[a[3:0]] <= mem_q[a[3:0]] & dout;
				end else if (setup_q != 2'd0) begin
					// failures set flags that stay until cleared
					sr_q <= sr_q | ((setup_q == 2'd1 && dout != 8'hD0) ? 3'b110 : 3'b001);
				end else begin
					case (dout)
					8'hFF: if (busy_q == 8'h00) mode_q <= 2'd0;
					8'h90: mode_q <= 2'd1;
					8'h70: mode_q <= 2'd2;
					8'h50: sr_q <= 3'b000;
					8'hB0: begin
						if (busy_q != 8'h00)
							susp_q <= 1'b1;
						mode_q <= 2'd2;
					end
					8'hD0: begin
						susp_q <= 1'b0;
						mode_q <= 2'd2;
					end
					8'h20: setup_q <= 2'd1;
					8'h40, 8'h10: setup_q <= 2'd2;
					default: mode_q <= mode_q;
					endcase
				end
			end
		end
	end
endmodule // fcs_flash_model

// *** verification/test_flash_command_status_interface.sv ***
// self-checking bench: controller driving the behavioural flash
// assumes fcs_regs.vh on the include path; short wake count for run time
`timescale 1ns/1ps
`include "fcs_regs.vh"
module test_flash_command_status_interface;
	reg         clk = 1'b0;
	reg         rstn, reg_wr, reg_rd, vpp_ok;
	reg  [3:0]  reg_addr;
	reg  [31:0] reg_wdata, s;
	wire [31:0] reg_rdata_q;
	wire [19:0] fa;
	wire [7:0]  fdo, fdi;
	wire        foe, cs_n, oe_n, we_n, pd_n, rb_n;
	integer     miscompares, checks_done, n;
	always #5 clk = ~clk;
	fcs_controller #(.WAKE_WR_CYC(4)) uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe(foe), .flash_dq_in(fdi),
		.chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(we_n),
		.power_down_n_q(pd_n), .ready_busy_n(rb_n));
	fcs_flash_model u_flash (.clk(clk), .a(fa), .dout(fdo), .doe(foe), .din(fdi),
		.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .pd_n(pd_n), .rb_n(rb_n), .vpp_ok(vpp_ok));
	task test_done;
		begin
			if (miscompares == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, output [31:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			// read data stand from the cycle after the strobe until the next read
			@(posedge clk);
			d = reg_rdata_q;
		end
	endtask
	task expr(input [3:0] a, input [31:0] e);
		begin
			rd(a, s);
			chk(s, e);
		end
	endtask
	task wait_bit(input integer b, input v);
		begin
			n = 0;
			repeat (2) @(posedge clk);
			rd(`FCS_REG_STATUS, s);
			while (s[b] !== v && n < 500) begin
				rd(`FCS_REG_STATUS, s);
				n = n + 1;
			end
			if (n == 500) begin
				miscompares = miscompares + 1;
				test_done;
			end
		end
	endtask
	task op(input [3:0] o);
		begin
			wr(`FCS_REG_CTRL, {23'h00_0000, 1'b1, 4'h0, o});
			wait_bit(0, 1'b0);
		end
	endtask
	task t_reset_wake;
		begin
			expr(`FCS_REG_FLASH_SR, 32'h0000_0080);
			expr(4'hF, 32'h0000_0000);
			chk(pd_n, 1'b0);
			wr(`FCS_REG_CTRL, 32'h0000_0100);
			wr(`FCS_REG_CTRL, 32'h0000_0104);
			rd(`FCS_REG_STATUS, s);
			chk(s[0], 1'b0);
			wait_bit(6, 1'b1);
			chk(pd_n, 1'b1);
		end
	endtask
	task t_ident_array;
		begin
			wr(`FCS_REG_ADDR, 32'h0000_0000);
			op(`FCS_OP_READ_ID);
			expr(`FCS_REG_RESULT, 32'h0000_005A);
			wr(`FCS_REG_ADDR, 32'h0000_0001);
			op(`FCS_OP_READ);
			expr(`FCS_REG_RESULT, 32'h0000_00C3);
			wr(`FCS_REG_ADDR, 32'h0000_0005);
			op(`FCS_OP_READ_ARRAY);
			op(`FCS_OP_READ);
			expr(`FCS_REG_RESULT, 32'h0000_0005);
		end
	endtask
	task t_write_erase;
		begin
			wr(`FCS_REG_DATA, 32'h0000_0001);
			op(`FCS_OP_WRITE);
			expr(`FCS_REG_FLASH_SR, 32'h0000_0080);
			op(`FCS_OP_READ_ARRAY);
			op(`FCS_OP_READ);
			expr(`FCS_REG_RESULT, 32'h0000_0001);
			op(`FCS_OP_ERASE);
			expr(`FCS_REG_FLASH_SR, 32'h0000_0080);
			op(`FCS_OP_READ_ARRAY);
			op(`FCS_OP_READ);
			expr(`FCS_REG_RESULT, 32'h0000_00FF);
		end
	endtask
	task t_supply_low;
		begin
			vpp_ok <= 1'b0;
			op(`FCS_OP_ERASE);
			expr(`FCS_REG_FLASH_SR, 32'h0000_0088);
			rd(`FCS_REG_STATUS, s);
			chk(s[4], 1'b1);
			op(`FCS_OP_CLEAR_STATUS);
			op(`FCS_OP_READ_STATUS);
			expr(`FCS_REG_FLASH_SR, 32'h0000_0080);
			rd(`FCS_REG_STATUS, s);
			chk(s[4], 1'b0);
			vpp_ok <= 1'b1;
		end
	endtask
	task start_erase;
		begin
			wr(`FCS_REG_CTRL, {23'h00_0000, 1'b1, 4'h0, `FCS_OP_ERASE});
			n = 0;
			while (rb_n !== 1'b0 && n < 300) begin
				@(posedge clk);
				n = n + 1;
			end
			chk(rb_n, 1'b0);
		end
	endtask
	task t_suspend;
		begin
			start_erase;
			op(`FCS_OP_SUSPEND);
			expr(`FCS_REG_FLASH_SR, 32'h0000_00C0);
			chk(rb_n, 1'b1);
			op(`FCS_OP_RESUME);
			expr(`FCS_REG_FLASH_SR, 32'h0000_0080);
		end
	endtask
	task t_abort;
		begin
			start_erase;
			wr(`FCS_REG_CTRL, 32'h0000_0000);
			repeat (2) @(posedge clk);
			chk({pd_n, rb_n}, 2'b01);
			wr(`FCS_REG_CTRL, 32'h0000_0100);
			wait_bit(6, 1'b1);
			op(`FCS_OP_READ);
			expr(`FCS_REG_RESULT, 32'h0000_00FF);
			op(`FCS_OP_READ_STATUS);
			expr(`FCS_REG_FLASH_SR, 32'h0000_0080);
		end
	endtask
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		vpp_ok = 1'b1;
		miscompares = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset_wake;
		t_ident_array;
		t_write_erase;
		t_supply_low;
		t_suspend;
		t_abort;
		test_done;
	end
endmodule // test_flash_command_status_interface
